// >>> src/pulse_quad_counter.sv
// pulse counters with debounce and result scaling, plus a quadrature decoder
// assumes pins arrive asynchronously and software issues one scan write per interval
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - count one chosen edge per enabled input
// - result per input: count, frequency, average
// - switch-closure inputs are debounced before counting
// - each input has its own 32-bit accumulator
// - scan captures every accumulator, then clears it
// - accumulator wraps; interval then flagged invalid
// - count resolution is one pulse per scan
// - quadrature phases: first two single-ended or control pins
// - position up when A leads, down otherwise
// - report net, direction, and per-direction counts
// - A leading B is reported as clockwise
// - single-edge: A rise up, A fall down
// - double-edge: count every A edge
// - quadruple-edge: count every edge of both phases
// - counting continues between scans without loss
module pulse_quad_counter #(
  parameter int DEBOUNCE_LEN = counter_pkg::DEBOUNCE_CYCLES
) (
  // clock, reset, enable
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           ce,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [counter_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // pulse pins
  input  wire logic [3:0]                     single_ended_inputs,
  input  wire logic [1:0]                     control_inputs,
  input  wire logic                           switch_closure_input,
  input  wire logic                           low_level_ac_input
);
  import counter_pkg::*;

  function automatic logic in_bank(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    in_bank = (a & BANK_MASK) == base;
  endfunction

  function automatic logic sync_differs(input logic a, input logic b);
    sync_differs = a ^ b;
  endfunction

  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_LEN - 1);

  // pin synchroniser; channel order se0..se3, ctl0, ctl1, sw, ll
  logic [NUM_CH-1:0] pin_meta;
  logic [NUM_CH-1:0] pin_sync;
  wire  [NUM_CH-1:0] pin_raw = {low_level_ac_input, switch_closure_input, control_inputs, single_ended_inputs};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (ce) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // registers written by software
  logic [CTRL_W-1:0] ctrl;
  logic [ACC_W-1:0]  recip;
  logic [CFG_W-1:0]  cfg [NUM_CH];

  // bus decode
  wire access    = ce & psel & penable & pready;
  wire wr_access = access & pwrite;
  wire [2:0] ch_sel = paddr[4:2];
  wire hit_fixed = (paddr == OFF_CTRL) | (paddr == OFF_SCAN) | (paddr == OFF_RECIP) | (paddr == OFF_STATUS)
                 | (paddr == OFF_QNET) | (paddr == OFF_QCW) | (paddr == OFF_QCCW);
  wire hit_any   = hit_fixed | in_bank(paddr, OFF_CHCFG) | in_bank(paddr, OFF_RESULT);
  wire scan      = wr_access & (paddr == OFF_SCAN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= CTRL_RESET;
      recip <= RECIP_RESET;
    end else if (ce && wr_access) begin
      if (paddr == OFF_CTRL)
        ctrl <= pwdata[CTRL_W-1:0];
      if (paddr == OFF_RECIP)
        recip <= pwdata;
    end
  end

  // per-channel state
  logic [ACC_W-1:0] acc     [NUM_CH];
  logic [ACC_W-1:0] snap    [NUM_CH];
  logic [ACC_W-1:0] hist    [NUM_CH][AVG_DEPTH];
  logic [ACC_W-1:0] result  [NUM_CH];
  logic [DEB_W-1:0] deb_cnt [NUM_CH];
  logic [NUM_CH-1:0] level;
  logic [NUM_CH-1:0] level_d;
  logic [NUM_CH-1:0] wrapped;
  logic [NUM_CH-1:0] invalid;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire cfg_wr  = wr_access & in_bank(paddr, OFF_CHCFG) & (ch_sel == 3'(g));
      wire sw_mode = cfg[g][CFG_SW];
      wire rise    = level[g] & ~level_d[g];
      wire fall    = ~level[g] & level_d[g];
      wire event_hit = cfg[g][CFG_EN] & (cfg[g][CFG_FALL] ? fall : rise);
      wire [2*ACC_W-1:0] prod = {{ACC_W{1'b0}}, acc[g]} * {{ACC_W{1'b0}}, recip};
      wire [ACC_W-1:0] freq_now = prod[RECIP_FRAC +: ACC_W];
      wire [ACC_W+1:0] hist_sum = {2'b00, hist[g][0]} + {2'b00, hist[g][1]} + {2'b00, hist[g][2]}
                                + {2'b00, hist[g][3]};
      wire [ACC_W-1:0] avg = hist_sum[AVG_SHIFT +: ACC_W];
      wire deb_move = sync_differs(pin_sync[g], level[g]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          cfg[g] <= CFG_RESET;
        else if (ce && cfg_wr)
          cfg[g] <= pwdata[CFG_W-1:0];
      end

      // bounce must settle for the full window; trades top rate for one count per closure
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level[g]   <= 1'b0;
          deb_cnt[g] <= '0;
        end else if (ce) begin
          if (!sw_mode) begin
            level[g]   <= pin_sync[g];
            deb_cnt[g] <= '0;
          end else if (!deb_move) begin
            deb_cnt[g] <= '0;
          end else if (deb_cnt[g] == DEB_LAST) begin
            level[g]   <= pin_sync[g];
            deb_cnt[g] <= '0;
          end else begin
            deb_cnt[g] <= deb_cnt[g] + 1'b1;
          end
        end
      end

      // an edge in the scan cycle opens the new interval at one, so none is lost
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_d[g] <= 1'b0;
          acc[g]     <= '0;
          snap[g]    <= '0;
          wrapped[g] <= 1'b0;
          invalid[g] <= 1'b0;
        end else if (ce) begin
          level_d[g] <= level[g];
          if (scan) begin
            snap[g]    <= acc[g];
            invalid[g] <= wrapped[g];
            acc[g]     <= {{(ACC_W-1){1'b0}}, event_hit};
            wrapped[g] <= 1'b0;
          end else if (event_hit) begin
            acc[g]     <= acc[g] + 1'b1;
            if (&acc[g])
              wrapped[g] <= 1'b1;
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          for (int k = 0; k < AVG_DEPTH; k++)
            hist[g][k] <= '0;
        end else if (ce && scan) begin
          hist[g][0] <= freq_now;
          for (int k = 1; k < AVG_DEPTH; k++)
            hist[g][k] <= hist[g][k-1];
        end
      end

      always_comb begin
        case (out_mode_type'(cfg[g][CFG_OUT +: 2]))
          OUT_COUNT: result[g] = snap[g];
          OUT_FREQ:  result[g] = hist[g][0];
          OUT_AVG:   result[g] = avg;
          default:   result[g] = snap[g];
        endcase
      end
    end
  endgenerate

  // quadrature decoder
  wire q_src   = ctrl[CTRL_QSRC];
  wire q_a     = q_src ? pin_sync[4] : pin_sync[0];
  wire q_b     = q_src ? pin_sync[5] : pin_sync[1];
  logic q_a_d;
  logic q_b_d;
  logic q_dir;
  logic [ACC_W-1:0] q_net;
  logic [ACC_W-1:0] q_cw;
  logic [ACC_W-1:0] q_ccw;
  logic [ACC_W-1:0] q_cw_snap;
  logic [ACC_W-1:0] q_ccw_snap;
  wire a_chg   = q_a ^ q_a_d;
  wire b_chg   = q_b ^ q_b_d;
  wire one_chg = a_chg ^ b_chg;
  // a legal single step moves forward exactly when the new A differs from the old B
  wire q_up    = q_a ^ q_b_d;
  logic q_step;

  always_comb begin
    case (quad_mode_type'(ctrl[CTRL_QMODE +: 2]))
      QUAD_X1: q_step = a_chg & ~b_chg & (q_a == q_up);
      QUAD_X2: q_step = a_chg & ~b_chg;
      QUAD_X4: q_step = one_chg;
      default: q_step = 1'b0;
    endcase
  end

  wire q_count = ctrl[CTRL_QEN] & q_step;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_a_d <= 1'b0;
      q_b_d <= 1'b0;
      q_dir <= 1'b0;
      q_net <= '0;
    end else if (ce) begin
      q_a_d <= q_a;
      q_b_d <= q_b;
      if (q_count) begin
        q_dir <= q_up;
        q_net <= q_up ? q_net + 1'b1 : q_net - 1'b1;
      end
    end
  end

  // per-direction counts are interval counts, captured with the pulse channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_cw       <= '0;
      q_ccw      <= '0;
      q_cw_snap  <= '0;
      q_ccw_snap <= '0;
    end else if (ce) begin
      if (scan) begin
        q_cw_snap  <= q_cw;
        q_ccw_snap <= q_ccw;
        q_cw       <= {{(ACC_W-1){1'b0}}, q_count & q_up};
        q_ccw      <= {{(ACC_W-1){1'b0}}, q_count & ~q_up};
      end else if (q_count) begin
        if (q_up)
          q_cw  <= q_cw + 1'b1;
        else
          q_ccw <= q_ccw + 1'b1;
      end
    end
  end

  // read mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (in_bank(paddr, OFF_CHCFG))
      rd_word = {{(32-CFG_W){1'b0}}, cfg[ch_sel]};
    else if (in_bank(paddr, OFF_RESULT))
      rd_word = result[ch_sel];
    else if (paddr == OFF_CTRL)
      rd_word = {{(32-CTRL_W){1'b0}}, ctrl};
    else if (paddr == OFF_RECIP)
      rd_word = recip;
    else if (paddr == OFF_STATUS)
      rd_word = {{(31-STAT_DIR){1'b0}}, q_dir, invalid};
    else if (paddr == OFF_QNET)
      rd_word = q_net;
    else if (paddr == OFF_QCW)
      rd_word = q_cw_snap;
    else if (paddr == OFF_QCCW)
      rd_word = q_ccw_snap;
  end

  // no wait state: data and error are latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~hit_any;
        pready  <= 1'b1;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule // pulse_quad_counter

`default_nettype wire

// >>> pkg/counter_pkg.sv
// constants, field layout and modes of the pulse and quadrature counter
// assumes a 100 MHz pclk and a 32-bit APB register bus
package counter_pkg;
  localparam int NUM_CH  = 8;
  localparam int ACC_W   = 32;
  localparam int ADDR_W  = 8;
  localparam int DEB_W   = 16;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SCAN   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RECIP  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_QNET   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_QCW    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_QCCW   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CHCFG  = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h40;
  localparam logic [ADDR_W-1:0] BANK_MASK  = 8'hE0;
  // control register fields
  localparam int CTRL_QEN    = 0;
  localparam int CTRL_QMODE  = 1;
  localparam int CTRL_QSRC   = 3;
  localparam int CTRL_W      = 4;
  // per-channel configuration fields, then the status direction bit
  localparam int CFG_EN      = 0;
  localparam int CFG_FALL    = 1;
  localparam int CFG_SW      = 2;
  localparam int CFG_OUT     = 3;
  localparam int CFG_W       = 5;
  localparam int STAT_DIR    = 8;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET  = 4'h0;
  localparam logic [CFG_W-1:0]  CFG_RESET   = 5'h00;
  localparam logic [ACC_W-1:0]  RECIP_RESET = 32'h0001_0000;
  // frequency scale is unsigned Q16.16 of 1/interval in seconds
  localparam int RECIP_FRAC  = 16;
  localparam int AVG_DEPTH   = 4;
  localparam int AVG_SHIFT   = 2;
  // timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int DEBOUNCE_US = 100;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  typedef enum logic [1:0] {OUT_COUNT, OUT_FREQ, OUT_AVG} out_mode_type;
  typedef enum logic [1:0] {QUAD_X1, QUAD_X2, QUAD_X4} quad_mode_type;
endpackage

// >>> dv/pulse_quad_counter_asserts.sv
// apb-side assertions for the pulse and quadrature counter
// assumes one pclk domain; bound onto every counter instance
`timescale 1ns/1ps
`default_nettype none
module pulse_quad_counter_asserts #(
  parameter int DEBOUNCE_LEN = 8
) (
  // clock, reset, enable
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           ce,
  // apb
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [counter_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                    prdata,
  input wire logic                           pready,
  input wire logic                           pslverr
);
  import counter_pkg::*;
  wire setup = psel && !penable && ce;
  // fixed words need alignment and stop at the ccw word; banks take any address below 0x60
  wire unmapped = (paddr < OFF_CHCFG) ? (paddr[1:0] != 2'b00 || paddr > OFF_QCCW) : (paddr >= 8'h60);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_follows: assert property (setup |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready && ce |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property ($rose(pready) |-> $past(setup))
    else $error("ready without setup");
  a_err_unmapped: assert property (setup && unmapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && !unmapped |=> !pslverr)
    else $error("mapped access refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error outside access cycle");
  a_scan_zero: assert property (setup && !pwrite && paddr == OFF_SCAN |=> prdata == 32'h0)
    else $error("scan word reads nonzero");
  a_rdata_hold: assert property (!setup |=> $stable(prdata))
    else $error("read data moved without setup");
endmodule // pulse_quad_counter_asserts

bind pulse_quad_counter pulse_quad_counter_asserts #(.DEBOUNCE_LEN(DEBOUNCE_LEN)) u_asserts (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

// >>> dv/pulse_sensor_model.sv
// pulse sensors, a bouncing switch and a shaft encoder on the counter pins
// assumes pin changes right after a pclk edge; pins are synchronised by the design
`timescale 1ns/1ps
`default_nettype none
module pulse_sensor_model (
  // clock
  input  wire logic       pclk,
  // pins, switch idles high through its pull-up
  output logic      [7:0] pins
);
  initial pins = 8'h40;
  task automatic step(input int ch, input logic v, input int hold);
    logic [7:0] nxt;
    @(posedge pclk);
    nxt = pins;
    nxt[ch] = v;
    pins <= nxt;
    repeat (hold) @(posedge pclk);
  endtask
  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      step(ch, 1'b1, 3);
      step(ch, 1'b0, 3);
    end
  endtask
  // one-cycle chatter on both close and open
  task automatic closures(input int n);
    repeat (n) begin
      step(6, 1'b0, 0);
      step(6, 1'b1, 0);
      step(6, 1'b0, 20);
      step(6, 1'b1, 0);
      step(6, 1'b0, 0);
      step(6, 1'b1, 20);
    end
  endtask
  // a leads b when cw, b leads a otherwise
  task automatic quad(input int a, input bit cw, input int n);
    repeat (n) begin
      step(cw ? a : a + 1, 1'b1, 3);
      step(cw ? a + 1 : a, 1'b1, 3);
      step(cw ? a : a + 1, 1'b0, 3);
      step(cw ? a + 1 : a, 1'b0, 3);
    end
  endtask
endmodule // pulse_sensor_model
`default_nettype wire

// >>> dv/pulse_quad_counter_tb.sv
// self-checking bench for the pulse and quadrature counter over apb
// assumes the sensor model on the pins and the bound apb checker
`timescale 1ns/1ps
`default_nettype none
module pulse_quad_counter_tb;
  import counter_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              ce = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              pready;
  logic              pslverr;
  logic              err;
  logic [7:0]        pins;
  int                error_cnt = 0;
  int                checks_done = 0;
  int                cfgv [8] = '{0, 0, 1, 3, 9, 17, 5, 0};
  int                exp1 [8] = '{0, 0, 6, 6, 12, 3, 3, 0};
  int                exp2 [8] = '{0, 0, 0, 0, 0, 3, 0, 0};
  always #5 pclk = ~pclk;
  pulse_sensor_model src (.pclk(pclk), .pins(pins));
  pulse_quad_counter #(.DEBOUNCE_LEN(8)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_ended_inputs(pins[3:0]), .control_inputs(pins[5:4]),
    .switch_closure_input(pins[6]), .low_level_ac_input(pins[7])
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  initial begin
    int md, f, qnet;
    qnet = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFF_CTRL, 32'h0);
    rchk(OFF_RECIP, RECIP_RESET);
    rchk(OFF_CHCFG, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1);
    for (int i = 0; i < NUM_CH; i++) xfer(1'b1, 8'(OFF_CHCFG + 4 * i), 32'(cfgv[i]));
    xfer(1'b1, OFF_RECIP, 32'h0002_0000);
    xfer(1'b1, OFF_SCAN, 32'h0);
    for (int i = 2; i < 6; i++) src.pulses(i, 6);
    src.closures(3);
    src.pulses(7, 6);
    repeat (8) @(posedge pclk);
    xfer(1'b1, OFF_SCAN, 32'h0);
    for (int i = 0; i < NUM_CH; i++) rchk(8'(OFF_RESULT + 4 * i), 32'(exp1[i]));
    xfer(1'b1, OFF_SCAN, 32'h0);
    for (int i = 0; i < NUM_CH; i++) rchk(8'(OFF_RESULT + 4 * i), 32'(exp2[i]));
    for (int m = 0; m < 4; m++) begin
      md = (m == 3) ? 2 : m;
      f = 1 << md;
      xfer(1'b1, OFF_CTRL, 32'(1 + 2 * md + 8 * (m / 3)));
      xfer(1'b1, OFF_SCAN, 32'h0);
      src.quad(4 * (m / 3), 1'b1, 3);
      src.quad(4 * (m / 3), 1'b0, 2);
      src.quad(4 * (m / 3), 1'b1, 1);
      repeat (8) @(posedge pclk);
      xfer(1'b1, OFF_SCAN, 32'h0);
      qnet += 2 * f;
      rchk(OFF_QNET, 32'(qnet));
      rchk(OFF_QCW, 32'(4 * f));
      rchk(OFF_QCCW, 32'(2 * f));
      rchk(OFF_STATUS, 32'h0000_0100);
    end
    // position is read-only, so this write must not land
    xfer(1'b1, OFF_QNET, 32'hFFFF_FFFF);
    rchk(OFF_QNET, 32'(qnet));
    // mode 3 stops the decoder, output code 3 reads as count, low ce loses pin edges
    xfer(1'b1, OFF_CHCFG, 32'h0000_0019);
    xfer(1'b1, OFF_CTRL, 32'h0000_0007);
    xfer(1'b1, OFF_SCAN, 32'h0);
    @(posedge pclk) ce <= 1'b0;
    src.pulses(0, 2);
    @(posedge pclk) ce <= 1'b1;
    src.quad(0, 1'b1, 1);
    repeat (8) @(posedge pclk);
    xfer(1'b1, OFF_SCAN, 32'h0);
    rchk(OFF_QNET, 32'(qnet));
    rchk(OFF_QCW, 32'h0);
    rchk(OFF_RESULT, 32'h1);
    rchk(OFF_SCAN, 32'h0);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end
endmodule // pulse_quad_counter_tb
`default_nettype wire
